/* hw/abpf_formatter.sv */
// Window, binning and pixel formatter with its AHB-Lite register slave.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module abpf_formatter #(
	parameter int LEVEL_W = 14,
	parameter bit COLOUR = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sen_valid,
	input wire logic sen_sof,
	input wire logic sen_eol,
	input wire logic [LEVEL_W-1:0] sen_level,
	output logic pix_valid,
	output logic pix_sof,
	output logic pix_eol,
	output logic [11:0] pix_data,
	output logic [1:0] pix_phase
);
	import abpf_pkg::*;
	if (LEVEL_W < 12 || LEVEL_W > 16) begin : g_bad_level_w
		$error("LEVEL_W must lie between 12 and 16");
	end
	//////////////////////////////////////////////////////////////////////////////
	logic [CW-1:0] row_start, col_start, width, height, width_max, height_max;
	logic [CW-1:0] next_row_start, next_col_start, next_width, next_height;
	logic [CW-1:0] next_width_max, next_height_max;
	logic [PW-1:0] pitch, next_pitch;
	abpf_enc_e enc, next_enc;
	logic [4:0] bpp, next_bpp;
	logic hbin2, vbin2, next_hbin2, next_vbin2;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic [15:0] frame_lines, fl_comb;
	logic take;
	// Pitch from width in units of eight pixels.
	function automatic logic [PW-1:0] pitch_of(logic [CW-1:0] w, abpf_enc_e e);
		pitch_of = PW'(w >> 3) * PW'(abpf_step(e));
	endfunction : pitch_of
	// Whole eight-pixel units held in a pitch; the divisors are all constants.
	function automatic logic [CW-1:0] units_of(logic [PW-1:0] p, abpf_enc_e e);
		unique case (abpf_step(e))
			5'h08: units_of = CW'(p >> 3);
			5'h0c: units_of = CW'(p / 14'h000c);
			5'h18: units_of = CW'(p / 14'h0018);
			default: units_of = CW'(p >> 4);
		endcase
	endfunction : units_of
	abpf_frame_lines u_lines (
		.row_start(row_start),
		.height(height),
		.hbin2(hbin2),
		.lines(fl_comb)
	);
	//////////////////////////////////////////////////////////////////////////////
	assign take = hsel && htrans[1] && hready;
	always_comb begin
		logic [CW-1:0] v;
		logic [CW-1:0] lim;
		logic [CW-1:0] u;
		v = '0;
		lim = '0;
		u = '0;
		next_row_start = row_start;
		next_col_start = col_start;
		next_width = width;
		next_height = height;
		next_width_max = width_max;
		next_height_max = height_max;
		next_pitch = pitch;
		next_enc = enc;
		next_bpp = bpp;
		next_hbin2 = hbin2;
		next_vbin2 = vbin2;
		next_wr_pend = take && hwrite;
		next_wr_addr = take ? haddr[7:0] : wr_addr;
		if (wr_pend) begin
			case (wr_addr)
				A_ROW: begin
					v = hwdata[CW-1:0];
					lim = height_max - height;
					next_row_start = (v > lim) ? lim : v;
					if (COLOUR) begin
						next_row_start[0] = 1'b0;
					end
				end
				A_COL: begin
					v = hwdata[CW-1:0];
					lim = width_max - width;
					next_col_start = (v > lim) ? lim : v;
				end
				A_WIDTH: begin
					next_width_max = hbin2 ? width_max : WIDTH_MAX1;
					lim = next_width_max - col_start;
					v = (hwdata[31:CW] != '0 || hwdata[CW-1:0] > lim) ? lim : hwdata[CW-1:0];
					v = v & ~(WIDTH_STEP - 12'h001);
					next_width = (v < WIDTH_STEP) ? WIDTH_STEP : v;
					next_pitch = pitch_of(next_width, enc);
				end
				A_HEIGHT: begin
					next_height_max = vbin2 ? height_max : HEIGHT_MAX1;
					lim = next_height_max - row_start;
					v = (hwdata[31:CW] != '0 || hwdata[CW-1:0] > lim) ? lim : hwdata[CW-1:0];
					next_height = (v == '0) ? 12'h001 : v;
				end
				A_PITCH: begin
					lim = (width_max - col_start) >> 3;
					u = units_of(hwdata[PW-1:0], enc);
					if (hwdata[31:PW] != '0 || u > lim) begin
						u = lim;
					end
					u = (u == '0) ? 12'h001 : u;
					next_width = u << 3;
					next_pitch = pitch_of(next_width, enc);
				end
				A_ENC: begin
					if (hwdata[2:0] != 3'h7) begin
						next_enc = abpf_enc_e'(hwdata[2:0]);
						next_bpp = abpf_bpp(abpf_enc_e'(hwdata[2:0]));
						next_pitch = pitch_of(width, abpf_enc_e'(hwdata[2:0]));
					end
				end
				A_BIN: begin
					// Colour parts ignore binning writes; leaving binning keeps the limits.
					next_hbin2 = !COLOUR && hwdata[0];
					next_vbin2 = !COLOUR && hwdata[1];
					if (next_hbin2 && !hbin2) begin
						next_width_max = WIDTH_MAX2;
						v = (width > WIDTH_MAX2) ? WIDTH_MAX2 : width;
						next_width = v;
						next_col_start = (col_start > WIDTH_MAX2 - v) ? WIDTH_MAX2 - v : col_start;
						next_pitch = pitch_of(v, enc);
					end
					if (next_vbin2 && !vbin2) begin
						next_height_max = HEIGHT_MAX2;
						v = (height > HEIGHT_MAX2) ? HEIGHT_MAX2 : height;
						next_height = v;
						next_row_start = (row_start > HEIGHT_MAX2 - v) ? HEIGHT_MAX2 - v : row_start;
					end
				end
				default: begin
				end
			endcase
		end
		// Reading the post-write values keeps a read right behind a write coherent for all but the line count and line time.
		next_hrdata = 32'h0;
		if (take && !hwrite) begin
			case (haddr[7:0])
				A_ROW: next_hrdata = {20'h0, next_row_start};
				A_COL: next_hrdata = {20'h0, next_col_start};
				A_WIDTH: next_hrdata = {20'h0, next_width};
				A_HEIGHT: next_hrdata = {20'h0, next_height};
				A_ENC: next_hrdata = {29'h0, next_enc};
				A_PITCH: next_hrdata = {18'h0, next_pitch};
				A_BIN: next_hrdata = {30'h0, next_vbin2, next_hbin2};
				A_BPP: next_hrdata = {27'h0, next_bpp};
				A_LINES: next_hrdata = {16'h0, frame_lines};
				A_LINECYC: next_hrdata = {16'h0, hbin2 ? LINE_CYC_BIN : LINE_CYC_UNB};
				A_WMAX: next_hrdata = {20'h0, next_width_max};
				A_HMAX: next_hrdata = {20'h0, next_height_max};
				default: next_hrdata = 32'h0;
			endcase
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			row_start <= OB_ROWS;
			col_start <= OB_COLS;
			width <= EFF_WIDTH;
			height <= EFF_LINES;
			width_max <= WIDTH_MAX1;
			height_max <= HEIGHT_MAX1;
			pitch <= 14'h0ce0;
			enc <= ENC_MONO8;
			bpp <= 5'h08;
			hbin2 <= 1'b0;
			vbin2 <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			frame_lines <= 16'h0;
		end else begin
			row_start <= next_row_start;
			col_start <= next_col_start;
			width <= next_width;
			height <= next_height;
			width_max <= next_width_max;
			height_max <= next_height_max;
			pitch <= next_pitch;
			enc <= next_enc;
			bpp <= next_bpp;
			hbin2 <= next_hbin2;
			vbin2 <= next_vbin2;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			frame_lines <= fl_comb;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	logic [CW-1:0] row, col, next_row, next_col, cur_row, cur_col, rel_col, out_col;
	logic [CW:0] hspan;
	logic in_win, last_col, emit;
	logic [LEVEL_W-1:0] held, next_held;
	logic [LEVEL_W:0] sum;
	logic sof_pend, next_sof_pend;
	logic [11:0] code;
	logic next_pix_valid, next_pix_sof, next_pix_eol;
	logic [1:0] next_pix_phase;
	abpf_level_map #(.IN_W(LEVEL_W + 1)) u_map (
		.level(sum),
		.depth(abpf_depth(enc)),
		.code(code)
	);
	// Vertical binning is charge binning in the sensor, so rows arrive already combined.
	always_comb begin
		cur_row = sen_sof ? '0 : row;
		cur_col = sen_sof ? '0 : col;
		hspan = hbin2 ? {width, 1'b0} : {1'b0, width};
		in_win = cur_row >= row_start && {1'b0, cur_row} < {1'b0, row_start} + {1'b0, height}
			&& cur_col >= col_start
			&& {1'b0, cur_col} < {1'b0, col_start} + hspan;
		rel_col = cur_col - col_start;
		last_col = {1'b0, rel_col} == hspan - 13'h0001;
		out_col = hbin2 ? rel_col >> 1 : rel_col;
		emit = sen_valid && in_win && !(hbin2 && !rel_col[0]);
		sum = hbin2 ? {1'b0, held} + {1'b0, sen_level} : {1'b0, sen_level};
		next_held = (sen_valid && in_win) ? sen_level : held;
		next_row = row;
		next_col = col;
		if (sen_valid) begin
			next_row = sen_eol ? cur_row + 12'h001 : cur_row;
			next_col = sen_eol ? '0 : cur_col + 12'h001;
		end
		next_sof_pend = (sof_pend || (sen_valid && sen_sof)) && !emit;
		next_pix_valid = emit;
		next_pix_sof = emit && (sof_pend || sen_sof);
		next_pix_eol = emit && last_col;
		// Colour rows start on an even row, so relative parity names the mosaic site.
		next_pix_phase = {cur_row[0] ^ row_start[0], out_col[0]};
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			row <= '0;
			col <= '0;
			held <= '0;
			sof_pend <= 1'b0;
			pix_valid <= 1'b0;
			pix_sof <= 1'b0;
			pix_eol <= 1'b0;
			pix_data <= 12'h000;
			pix_phase <= 2'h0;
		end else begin
			row <= next_row;
			col <= next_col;
			held <= next_held;
			sof_pend <= next_sof_pend;
			pix_valid <= next_pix_valid;
			pix_sof <= next_pix_sof;
			pix_eol <= next_pix_eol;
			pix_data <= code;
			pix_phase <= next_pix_phase;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_hb_fall;
		$fell(hbin2) ##0 !(wr_pend && wr_addr == A_WIDTH);
	endsequence
	sequence s_rd_width;
		take && !hwrite && haddr[7:0] == A_WIDTH && !wr_pend;
	endsequence
	// Ready stays low until the first edge after reset, the same edge on which the line count first loads.
	sequence s_full_unb;
		hreadyout && !hbin2 && row_start == OB_ROWS && height == EFF_LINES;
	endsequence
	AST_WIDTH_STEP: assert property (width[2:0] == 3'h0 && width >= WIDTH_STEP)
		else $error("width not a multiple of eight pixels");
	AST_PITCH_LINK: assert property ($changed(width) |-> pitch == pitch_of(width, enc))
		else $error("pitch does not follow width");
	AST_WIN_BOUND: assert property ({1'b0, col_start} + {1'b0, width} <= 13'h0d00)
		else $error("window exceeds sensor columns");
	AST_HBIN_MAX: assert property ($rose(hbin2) |-> width <= WIDTH_MAX2 && width_max == WIDTH_MAX2)
		else $error("horizontal binning did not cap width");
	AST_VBIN_MAX: assert property (vbin2 |-> height <= HEIGHT_MAX2)
		else $error("vertical binning height above limit");
	AST_ROW_EVEN: assert property (COLOUR |-> !row_start[0])
		else $error("colour row start is odd");
	AST_BPP: assert property ($changed(enc) |-> bpp == abpf_bpp(enc))
		else $error("bits per pixel not updated");
	AST_NO_RESTORE: assert property (s_hb_fall |-> width_max == WIDTH_MAX2)
		else $error("width maximum restored without rewrite");
	AST_READ_WIDTH: assert property (s_rd_width |=> hrdata == {20'h0, width} && hreadyout)
		else $error("width readback wrong");
	AST_LINES_FULL: assert property (s_full_unb ##1 s_full_unb |-> frame_lines == 16'h09dc)
		else $error("full frame line count wrong");
	AST_CODE8: assert property (pix_valid && abpf_depth(enc) == 2'h0 |-> pix_data[11:8] == 4'h0)
		else $error("eight-bit code out of range");
	AST_PHASE: assert property (pix_valid && pix_sof && COLOUR |-> pix_phase == 2'h0)
		else $error("colour frame does not start on green-red");
endmodule : abpf_formatter

/* hw/abpf_pkg.sv */
// Constants, types and helper functions of the window, binning and pixel formatter.
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package abpf_pkg;
	localparam int CW = 12;
	localparam int PW = 14;
	localparam logic [7:0] A_ROW = 8'h00;
	localparam logic [7:0] A_COL = 8'h04;
	localparam logic [7:0] A_WIDTH = 8'h08;
	localparam logic [7:0] A_HEIGHT = 8'h0c;
	localparam logic [7:0] A_ENC = 8'h10;
	localparam logic [7:0] A_PITCH = 8'h14;
	localparam logic [7:0] A_BIN = 8'h18;
	localparam logic [7:0] A_BPP = 8'h1c;
	localparam logic [7:0] A_LINES = 8'h20;
	localparam logic [7:0] A_LINECYC = 8'h24;
	localparam logic [7:0] A_WMAX = 8'h28;
	localparam logic [7:0] A_HMAX = 8'h2c;
	localparam logic [CW-1:0] OB_ROWS = 12'h004;
	localparam logic [CW-1:0] OB_COLS = 12'h010;
	localparam logic [CW-1:0] EFF_WIDTH = 12'hce0;
	localparam logic [CW-1:0] EFF_LINES = 12'h9a8;
	localparam logic [CW-1:0] WIDTH_MAX1 = 12'hd00;
	localparam logic [CW-1:0] WIDTH_MAX2 = 12'h680;
	localparam logic [CW-1:0] HEIGHT_MAX1 = 12'h9ac;
	localparam logic [CW-1:0] HEIGHT_MAX2 = 12'h4d8;
	localparam logic [CW-1:0] WIDTH_STEP = 12'h008;
	localparam logic [15:0] LAST_ROW = 16'h09a7;
	localparam logic [15:0] OVH_UNB = 16'h0034;
	localparam logic [15:0] OVH_BIN = 16'h001a;
	localparam int LINE_NS_UNB = 38790;
	localparam int LINE_NS_BIN = 42125;
	localparam int CLK_NS = 50;
	localparam logic [15:0] LINE_CYC_UNB = 16'(LINE_NS_UNB / CLK_NS);
	localparam logic [15:0] LINE_CYC_BIN = 16'(LINE_NS_BIN / CLK_NS);
	localparam logic [11:0] MAX12 = 12'hfff;
	typedef enum logic [2:0] {
		ENC_MONO8 = 3'h0, ENC_MONO10P = 3'h1, ENC_MONO10 = 3'h2, ENC_MONO12 = 3'h3,
		ENC_MONO12P = 3'h4, ENC_RGB8 = 3'h5, ENC_YUV422 = 3'h6
	} abpf_enc_e;
	// Pitch step in bytes for eight pixels of the given encoding.
	function automatic logic [4:0] abpf_step(abpf_enc_e e);
		unique case (e)
			ENC_MONO8: abpf_step = 5'h08;
			ENC_MONO10P, ENC_MONO12P: abpf_step = 5'h0c;
			ENC_RGB8: abpf_step = 5'h18;
			default: abpf_step = 5'h10;
		endcase
	endfunction : abpf_step
	function automatic logic [4:0] abpf_bpp(abpf_enc_e e);
		abpf_bpp = 5'(abpf_step(e));
	endfunction : abpf_bpp
	// Output depth: 0 is 8 bits, 1 is 10 bits, 2 is 12 bits.
	function automatic logic [1:0] abpf_depth(abpf_enc_e e);
		unique case (e)
			ENC_MONO10P, ENC_MONO10: abpf_depth = 2'h1;
			ENC_MONO12, ENC_MONO12P: abpf_depth = 2'h2;
			default: abpf_depth = 2'h0;
		endcase
	endfunction : abpf_depth
endpackage : abpf_pkg

/* hw/abpf_level_map.sv */
// Sensor level to 8, 10 or 12-bit output code mapping.
`timescale 1ns/10ps
module abpf_level_map #(
	parameter int IN_W = 15
) (
	input wire logic [IN_W-1:0] level,
	input wire logic [1:0] depth,
	output logic [11:0] code
);
	import abpf_pkg::*;
	logic [11:0] sat;
	// The sensor scale is that of the 12-bit code, so narrower codes drop low bits.
	always_comb begin
		sat = (level > IN_W'(MAX12)) ? MAX12 : level[11:0];
		unique case (depth)
			2'h1: code = {2'h0, sat[11:2]};
			2'h2: code = sat;
			default: code = {4'h0, sat[11:4]};
		endcase
	end
endmodule : abpf_level_map

/* hw/abpf_frame_lines.sv */
// Sensor lines read per frame from window row start, height and binning.
`timescale 1ns/10ps
module abpf_frame_lines (
	input wire logic [11:0] row_start,
	input wire logic [11:0] height,
	input wire logic hbin2,
	output logic [15:0] lines
);
	import abpf_pkg::*;
	logic signed [16:0] s;
	logic signed [16:0] st;
	logic signed [16:0] e;
	logic signed [16:0] mid;
	always_comb begin
		s = (row_start < OB_ROWS) ? 17'sd4 : $signed({5'h00, row_start});
		if (hbin2) begin
			st = ((s <<< 1) - 17'sd8) & ~17'sd3;
			e = $signed({1'b0, LAST_ROW}) - (($signed({5'h00, height}) <<< 1) + (s <<< 1) - 17'sd9);
		end else begin
			st = (s - 17'sd4) & ~17'sd3;
			e = $signed({1'b0, LAST_ROW}) - ($signed({5'h00, height}) + s - 17'sd5);
		end
		if (e < 17'sd0) begin
			e = 17'sd0;
		end
		e = e & ~17'sd3;
		mid = $signed({1'b0, LAST_ROW}) - e - st + 17'sd1;
		if (hbin2) begin
			mid = mid >>> 1;
			lines = 16'((st >>> 2) + mid + (e >>> 2)) + OVH_BIN;
		end else begin
			lines = 16'((st >>> 2) + mid + (e >>> 2)) + OVH_UNB;
		end
	end
endmodule : abpf_frame_lines

/* test/abpf_stream_sink.sv */
// Receiving host model that records every formatted pixel it is handed.
`timescale 1ns/10ps
module abpf_stream_sink (
	input wire logic clk,
	input wire logic pix_valid,
	input wire logic pix_sof,
	input wire logic pix_eol,
	input wire logic [11:0] pix_data,
	input wire logic [1:0] pix_phase
);
	logic [15:0] rx_q[$];
	//////////////////////////////////////////////////////////////////////////////
	// The host has no back-pressure, so a pulse missed here is a pixel lost for good.
	always @(posedge clk) begin
		if (pix_valid === 1'b1) begin
			rx_q.push_back({pix_sof, pix_eol, pix_phase, pix_data});
		end
	end
endmodule : abpf_stream_sink

/* test/test_aoi_binning_pixel_formatter.sv */
// Self-checking bench of the window, binning and pixel formatter.
`timescale 1ns/10ps
module test_aoi_binning_pixel_formatter;
	import abpf_pkg::*;
	logic clk, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [31:0] hrdata_c, rdata_c;
	logic [1:0] htrans, pix_phase;
	logic [2:0] hsize;
	logic sen_valid, sen_sof, sen_eol, pix_valid, pix_sof, pix_eol;
	logic [13:0] sen_level;
	logic [11:0] pix_data;
	int mismatches, checked;
	int steps[7] = '{8, 12, 16, 16, 12, 24, 16};
	//////////////////////////////////////////////////////////////////////////////
	abpf_formatter #(.LEVEL_W(14), .COLOUR(1'b0)) u_abpf_formatter (.clk(clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sen_valid(sen_valid), .sen_sof(sen_sof), .sen_eol(sen_eol),
		.sen_level(sen_level), .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_eol(pix_eol),
		.pix_data(pix_data), .pix_phase(pix_phase));
	abpf_stream_sink u_abpf_stream_sink (.clk(clk), .pix_valid(pix_valid), .pix_sof(pix_sof),
		.pix_eol(pix_eol), .pix_data(pix_data), .pix_phase(pix_phase));
	// The colour variant shares every input, so each write lands in both register sets.
	abpf_formatter #(.LEVEL_W(14), .COLOUR(1'b1)) u_abpf_formatter_colour (.clk(clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata_c), .hreadyout(), .hresp(),
		.sen_valid(sen_valid), .sen_sof(sen_sof), .sen_eol(sen_eol), .sen_level(sen_level),
		.pix_valid(), .pix_sof(), .pix_eol(), .pix_data(), .pix_phase());
	//////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask : chk
	// Called just after a rising edge; the wait is bounded so a dead slave cannot hang the run.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		r = hrdata;
		rdata_c = hrdata_c;
		if (n >= 100) begin
			mismatches++;
			$display("MISMATCH %0t bus wait ran out", $time);
			stop_test();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e, m);
		chk(32'(hresp), 32'h0, "response code");
	endtask : rd_chk
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_chk(A_ROW, 32'h4, "row start");
		rd_chk(A_COL, 32'h10, "col start");
		rd_chk(A_WIDTH, 32'hce0, "width");
		rd_chk(A_HEIGHT, 32'h9a8, "height");
		rd_chk(A_PITCH, 32'hce0, "pitch");
		rd_chk(A_BPP, 32'h8, "bits per pixel");
		rd_chk(A_WMAX, 32'hd00, "width max");
		rd_chk(A_HMAX, 32'h9ac, "height max");
		rd_chk(A_LINECYC, 32'h307, "line time");
		wr(8'h40, 32'h0000ffff);
		rd_chk(8'h40, 32'h0, "unmapped");
	endtask : t_reset
	task automatic t_enc();
		for (int e = 0; e < 7; e++) begin
			wr(A_ENC, 32'(e));
			wr(A_WIDTH, 32'h320);
			rd_chk(A_BPP, 32'(steps[e]), "bpp per encoding");
			rd_chk(A_PITCH, 32'(100 * steps[e]), "pitch from width");
			wr(A_PITCH, 32'(50 * steps[e]));
			rd_chk(A_WIDTH, 32'h190, "width from pitch");
		end
		wr(A_ENC, 32'h7);
		rd_chk(A_ENC, 32'h6, "encoding seven");
		wr(A_PITCH, 32'h0);
		rd_chk(A_PITCH, 32'h10, "pitch minimum");
		wr(A_ENC, 32'h0);
		wr(A_COL, 32'h0);
		wr(A_WIDTH, 32'hd00);
		rd_chk(A_WIDTH, 32'hd00, "full width");
		rd_chk(A_PITCH, 32'hd00, "full pitch");
		wr(A_WIDTH, 32'h8);
		wr(A_COL, 32'h10);
		wr(A_WIDTH, 32'hd00);
		rd_chk(A_WIDTH, 32'hcf0, "width clamp");
	endtask : t_enc
	task automatic t_binmax();
		wr(A_COL, 32'h0);
		wr(A_WIDTH, 32'hd00);
		wr(A_BIN, 32'h1);
		rd_chk(A_WMAX, 32'h680, "binned width max");
		chk(rdata_c, 32'hd00, "colour ignores binning");
		rd_chk(A_PITCH, 32'h680, "binned pitch");
		wr(A_BIN, 32'h0);
		rd_chk(A_WMAX, 32'h680, "width max kept");
		wr(A_WIDTH, 32'h8);
		rd_chk(A_WMAX, 32'hd00, "width max back");
		wr(A_BIN, 32'h2);
		rd_chk(A_HMAX, 32'h4d8, "binned height max");
		wr(A_BIN, 32'h0);
		rd_chk(A_HMAX, 32'h4d8, "height max kept");
		wr(A_HEIGHT, 32'h4);
		rd_chk(A_HMAX, 32'h9ac, "height max back");
	endtask : t_binmax
	//////////////////////////////////////////////////////////////////////////////
	function automatic int exp_lines(input int b, input int s0, input int h);
		int s, sa, ea;
		s = (s0 < 4) ? 4 : s0;
		if (b == 0) begin
			sa = ((s - 4) / 4) * 4;
			ea = ((2471 - (h + s - 5)) / 4) * 4;
			return sa / 4 + (2471 - ea - sa + 1) + ea / 4 + 52;
		end
		sa = ((2 * s - 8) / 4) * 4;
		ea = ((2471 - (2 * h + 2 * s - 9)) / 4) * 4;
		ea = (ea < 0) ? 0 : ea;
		return sa / 4 + (2471 - ea - sa + 1) / 2 + ea / 4 + 26;
	endfunction : exp_lines
	task automatic t_lines();
		int cb[8] = '{0, 0, 0, 0, 2, 1, 1, 3};
		int cs[8] = '{622, 932, 1086, 0, 3, 314, 468, 544};
		int ch[8] = '{1236, 618, 310, 2472, 100, 618, 308, 156};
		for (int i = 0; i < 8; i++) begin
			wr(A_BIN, 32'(cb[i]));
			wr(A_HEIGHT, 32'h1);
			wr(A_ROW, 32'(cs[i]));
			wr(A_HEIGHT, 32'(ch[i]));
			// The line count register lags the settings by one cycle.
			@(posedge clk);
			rd_chk(A_LINES, 32'(exp_lines(cb[i] % 2, cs[i], ch[i])), "frame lines");
			rd_chk(A_LINECYC, (cb[i] % 2 == 1) ? 32'h34a : 32'h307, "line time");
		end
		wr(A_BIN, 32'h0);
	endtask : t_lines
	// Levels rise across the frame so the far corner saturates; frame origin sits at black, window origin at 128.
	function automatic int lvl(input int r, input int c);
		int v;
		v = 900 * r + 230 * c - 1232;
		return (v < 0) ? 0 : v;
	endfunction : lvl
	task automatic t_stream(input int b, input int e);
		int c, v, sh;
		sh = (e == 0) ? 4 : ((e == 2) ? 2 : 0);
		wr(A_BIN, 32'(b));
		wr(A_HEIGHT, 32'h1);
		wr(A_WIDTH, 32'h8);
		wr(A_COL, 32'h2);
		wr(A_ROW, 32'h1);
		rd_chk(A_ROW, 32'h1, "mono row start");
		chk(rdata_c, 32'h0, "colour row start even");
		wr(A_HEIGHT, 32'h2);
		wr(A_ENC, 32'(e));
		u_abpf_stream_sink.rx_q.delete();
		for (int r = 0; r < 4; r++) begin
			for (int k = 0; k < 20; k++) begin
				sen_valid <= 1'b1;
				sen_sof <= (r == 0 && k == 0);
				sen_eol <= (k == 19);
				sen_level <= 14'(lvl(r, k));
				@(posedge clk);
			end
		end
		sen_valid <= 1'b0;
		sen_sof <= 1'b0;
		sen_eol <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(u_abpf_stream_sink.rx_q.size()), 32'h10, "pixel count");
		for (int i = 0; i < 16 && i < u_abpf_stream_sink.rx_q.size(); i++) begin
			c = 2 + ((b == 1) ? 2 * (i % 8) : i % 8);
			v = lvl(1 + i / 8, c) + ((b == 1) ? lvl(1 + i / 8, c + 1) : 0);
			v = ((v > 4095) ? 4095 : v) >> sh;
			chk(32'(u_abpf_stream_sink.rx_q[i]), {16'h0, i == 0, i % 8 == 7, 2'(((i / 8) % 2) * 2
				+ i % 2), 12'(v)}, "pixel");
		end
		wr(A_BIN, 32'h0);
	endtask : t_stream
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		mismatches = 0;
		checked = 0;
		rst = 1'b1;
		{hsel, hwrite, sen_valid, sen_sof, sen_eol} = 5'h00;
		{haddr, hwdata, htrans, hsize, sen_level} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_enc();
		t_binmax();
		t_lines();
		t_stream(0, 0);
		t_stream(0, 2);
		t_stream(0, 3);
		t_stream(1, 3);
		stop_test();
	end
endmodule : test_aoi_binning_pixel_formatter
